// >>> hdl/wslc_pkg.sv
// Shared constants and carrier types of the wireless sensor link controller
package wslc_pkg;

  // ------------------------------
  // Timebase
  // ------------------------------
  localparam int unsigned    CLK_PERIOD_NS  = 5;              // 200 MHz system clock
  localparam longint unsigned TICK_PERIOD_NS = 64'h3B9ACA00;  // One second per tick
  localparam int unsigned    TICK_CYCLES    = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
  localparam int             TW             = 12;             // Seconds counter width

  // ------------------------------
  // Intervals in seconds
  // ------------------------------
  localparam logic [TW-1:0] ASSOC_REPLY_S = 12'h002;  // Reply window for a request
  localparam logic [TW-1:0] ASSOC_RETRY_S = 12'h258;  // 10 minutes
  localparam logic [TW-1:0] LOST_ASSOC_S  = 12'hBB8;  // 50 minutes
  localparam logic [TW-1:0] RESEND_S      = 12'h01E;  // 30 seconds
  localparam logic [TW-1:0] TEMP_MIN_S    = 12'h01E;  // 30 seconds
  localparam logic [TW-1:0] TEMP_MAX_S    = 12'h384;  // 15 minutes
  localparam logic [TW-1:0] SETPT_MIN_S   = 12'h00A;  // 10 seconds
  localparam logic [TW-1:0] TEST_LAMP_S   = 12'h005;  // 5 seconds

  // ------------------------------
  // Temperatures: zone in 0.1 F, setpoint in 0.1 C
  // ------------------------------
  localparam logic [15:0] TEMP_BAND_LO  = 16'h0258;  // 60.0 F
  localparam logic [15:0] TEMP_BAND_HI  = 16'h0320;  // 80.0 F
  localparam logic [15:0] TEMP_STEP_IN  = 16'h0002;  // 0.2 F
  localparam logic [15:0] TEMP_STEP_OUT = 16'h0005;  // 0.5 F
  localparam logic [15:0] SETPT_MIN     = 16'h0064;  // 10.0 C = 50 F
  localparam logic [15:0] SETPT_MAX     = 16'h0140;  // 32.0 C = 89.6 F
  localparam logic [15:0] SETPT_STEP    = 16'h0001;  // 0.1 C
  localparam logic [2:0]  MISS_LIMIT    = 3'h3;      // Unanswered resends before lost

  // ------------------------------
  // Register map (byte offsets)
  // ------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TEMP   = 8'h04;
  localparam logic [7:0] REG_SETPT  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int         CTRL_ASSOC_BIT = 0;

  // ------------------------------
  // Message kinds on the radio modem port
  // ------------------------------
  localparam logic [2:0] MSG_ASSOC_REQ = 3'h1;
  localparam logic [2:0] MSG_DISASSOC  = 3'h2;
  localparam logic [2:0] MSG_TEMP      = 3'h3;
  localparam logic [2:0] MSG_SETPT     = 3'h4;
  localparam logic [2:0] MSG_ACCEPT    = 3'h5;
  localparam logic [2:0] MSG_REFUSE    = 3'h6;
  localparam logic [2:0] MSG_ACK       = 3'h7;

  typedef struct packed {
    logic        valid;
    logic [2:0]  kind;
    logic [9:0]  addr;
    logic [15:0] data;
  } wslc_tx_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  kind;
    logic [9:0]  addr;
    logic [1:0]  power;
    logic [3:0]  channel;
  } wslc_rx_t;

endpackage

// >>> hdl/wslc_tick.sv
// One-second timebase tick divided from the system clock
`timescale 1ns/1ps
`default_nettype none
module wslc_tick #(
  parameter int unsigned CYCLES = 200000000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Tick pulse
  output logic      tick
);

  logic [31:0] div_reg;

  // Free-running divider, cleared at power-up so intervals start aligned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (div_reg == 32'(CYCLES - 1)) begin
      div_reg <= 32'h0;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h1;
      tick    <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/wslc_interval.sv
// Saturating seconds counter with a programmable limit
`timescale 1ns/1ps
`default_nettype none
module wslc_interval #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  // Result
  output logic      [W-1:0] count,
  output logic              expired
);

  // Saturates instead of wrapping so a late check never sees a short interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick && (count != {W{1'b1}})) begin
      count <= count + W'(1);
    end
  end

  assign expired = (count >= limit);

endmodule
`default_nettype wire

// >>> hdl/wslc_sensor_ctrl.sv
// Battery sensor side controller of a one-to-one wireless temperature link
//
// How it works
// RULE_01 - Associate only when both addresses match
// RULE_02 - Receiver keeps at most one partner
// RULE_03 - Receiver accepts addresses 001 through 999
// RULE_04 - Receiver at 000 defaults outputs, refuses
// RULE_05 - At 000: erase, disassociate, then hibernate
// RULE_06 - Receiver scans 20 s over 16 channels
// RULE_07 - Ready receiver flashes lamp three every 2 s
// RULE_08 - Sensor starts association automatically at power-up
// RULE_09 - Failed association retried every 10 minutes
// RULE_10 - Lost associated sensor requests every 50 minutes
// RULE_11 - Test shows strength and battery for 5 s
// RULE_12 - Receiver clamps replicated temperature 32 to 122 F
// RULE_13 - Setpoint limited to 50 through 89.6 F
// RULE_14 - Receiver unassociated power-up applies default outputs
// RULE_15 - Receiver at 000 shows two-blink pattern
// RULE_16 - Use channel and power given by receiver
// RULE_17 - Associated receiver defaults, then follows broadcasts
// RULE_18 - Receiver fails outputs after 35 silent minutes
// RULE_19 - Receiver opens setpoint output for basic sensor
// RULE_20 - Temperature 30 s to 15 min, setpoint 10 s
// RULE_21 - Unanswered message resent every 30 seconds
// RULE_22 - Send on 0.2/0.5 F or 0.1 C change
// RULE_23 - All intervals from one divided one-second tick
`timescale 1ns/1ps
`default_nettype none
module wslc_sensor_ctrl
  import wslc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // APB register port
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Rotary address pins, one BCD digit each
  input  wire logic [3:0]  ADDRESS_DIGIT_HUNDREDS,
  input  wire logic [3:0]  ADDRESS_DIGIT_TENS,
  input  wire logic [3:0]  ADDRESS_DIGIT_UNITS,
  // Front panel pins
  input  wire logic        TEST_BUTTON_N,
  input  wire logic        BATTERY_OK,
  // Radio modem port, same clock domain
  input  wire logic [1:0]  LINK_RSSI,
  input  wire wslc_rx_t    LINK_RX,
  output wslc_tx_t         LINK_TX,
  output logic      [1:0]  RADIO_POWER,
  output logic      [3:0]  RADIO_CHANNEL,
  // Lamps and power state
  output logic             STATUS_LAMP_A,
  output logic             STATUS_LAMP_B,
  output logic             STATUS_LAMP_C,
  output logic             POWER_LAMP,
  output logic             HIBERNATE
);

  // ------------------------------
  // States
  // ------------------------------
  typedef enum logic [7:0] {
    ST_BOOT       = 8'h01,
    ST_HIBER      = 8'h02,
    ST_DISASSOC   = 8'h04,
    ST_ASSOC_REQ  = 8'h08,
    ST_ASSOC_WAIT = 8'h10,
    ST_RETRY      = 8'h20,
    ST_ONLINE     = 8'h40,
    ST_LOST       = 8'h80
  } wslc_state_t;

  wslc_state_t state_reg, state_next;
  logic [11:0] addr_meta_reg, addr_sync_reg;
  logic [1:0]  pin_meta_reg, pin_sync_reg;
  logic        test_prev_reg, boot_wait_reg, boot_done_reg;
  logic [9:0]  my_addr;
  logic        addr_zero, rx_ok, tick;
  logic        assoc_reg, pend_reg, force_temp_reg, manual_reg, lamp_on_reg;
  logic [2:0]  miss_reg, last_kind_reg;
  logic [15:0] last_data_reg, last_temp_reg, last_setpt_reg, temp_reg, setpt_reg;
  logic [15:0] temp_delta, temp_step, setpt_delta, wdat_sp;
  logic [11:0] wait_limit, temp_cnt;
  logic        wait_exp, setpt_exp, lamp_exp, wait_clear;
  logic        send_now, temp_due, setpt_due;
  logic [2:0]  send_kind;
  logic [15:0] send_data;
  logic        wr_en, rd_en;

  // ------------------------------
  // Pin synchronisers
  // ------------------------------
  // Two flops on every pin; only the second stage is ever read
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_meta_reg <= 12'h000;
      addr_sync_reg <= 12'h000;
      pin_meta_reg  <= 2'h3;
      pin_sync_reg  <= 2'h3;
    end else begin
      addr_meta_reg <= {ADDRESS_DIGIT_HUNDREDS, ADDRESS_DIGIT_TENS, ADDRESS_DIGIT_UNITS};
      addr_sync_reg <= addr_meta_reg;
      pin_meta_reg  <= {TEST_BUTTON_N, BATTERY_OK};
      pin_sync_reg  <= pin_meta_reg;
    end
  end

  // Decimal switch value; 000 is the hibernate setting
  assign my_addr   = 10'(addr_sync_reg[11:8]) * 10'h064 + 10'(addr_sync_reg[7:4]) * 10'h00A
                   + 10'(addr_sync_reg[3:0]);
  assign addr_zero = (addr_sync_reg == 12'h000);
  // Replies from another pair on the air are ignored
  assign rx_ok     = LINK_RX.valid && (LINK_RX.addr == my_addr); // RULE_01

  // ------------------------------
  // Timebase and interval counters
  // ------------------------------
  wslc_tick #(.CYCLES(TICK_CYCLES_P)) u_tick ( // RULE_23
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .tick  (tick)
  );

  wslc_interval #(.W(TW)) u_wait (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .clear   (wait_clear),
    .tick    (tick),
    .limit   (wait_limit),
    .count   (),
    .expired (wait_exp)
  );

  wslc_interval #(.W(TW)) u_temp (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .clear   (send_now && (send_kind == MSG_TEMP)),
    .tick    (tick),
    .limit   (TEMP_MAX_S),
    .count   (temp_cnt),
    .expired ()
  );

  wslc_interval #(.W(TW)) u_setpt (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .clear   (send_now && (send_kind == MSG_SETPT)),
    .tick    (tick),
    .limit   (SETPT_MIN_S),
    .count   (),
    .expired (setpt_exp)
  );

  wslc_interval #(.W(TW)) u_lamp (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .clear   (test_prev_reg && !pin_sync_reg[1]),
    .tick    (tick),
    .limit   (TEST_LAMP_S),
    .count   (),
    .expired (lamp_exp)
  );

  // The state timer serves the reply window, the retry waits and resends
  always_comb begin
    case (state_reg)
      ST_ASSOC_WAIT: wait_limit = ASSOC_REPLY_S;
      ST_RETRY:      wait_limit = ASSOC_RETRY_S; // RULE_09
      ST_LOST:       wait_limit = LOST_ASSOC_S;  // RULE_10
      default:       wait_limit = RESEND_S;      // RULE_21
    endcase
  end

  // ------------------------------
  // Change detection
  // ------------------------------
  // Finer step inside the comfort band, coarser outside it
  assign temp_delta = (temp_reg > last_temp_reg) ? temp_reg - last_temp_reg
                                                 : last_temp_reg - temp_reg;
  assign temp_step  = ((temp_reg >= TEMP_BAND_LO) && (temp_reg <= TEMP_BAND_HI))
                    ? TEMP_STEP_IN : TEMP_STEP_OUT;                           // RULE_22
  assign setpt_delta = (setpt_reg > last_setpt_reg) ? setpt_reg - last_setpt_reg
                                                    : last_setpt_reg - setpt_reg;
  assign temp_due  = force_temp_reg || (temp_cnt >= TEMP_MAX_S)
                  || ((temp_cnt >= TEMP_MIN_S) && (temp_delta >= temp_step)); // RULE_20
  assign setpt_due = setpt_exp && (setpt_delta >= SETPT_STEP);                // RULE_20

  // ------------------------------
  // Next state and message choice
  // ------------------------------
  always_comb begin
    state_next = state_reg;
    send_now   = 1'b0;
    send_kind  = MSG_TEMP;
    send_data  = 16'h0000;
    case (state_reg)
      ST_BOOT: begin
        if (boot_done_reg) begin
          state_next = addr_zero ? ST_DISASSOC : ST_ASSOC_REQ; // RULE_08
        end
      end
      ST_HIBER: begin
        if (!addr_zero) begin
          state_next = ST_ASSOC_REQ;
        end
      end
      ST_DISASSOC: begin
        send_now   = 1'b1; // RULE_05
        send_kind  = MSG_DISASSOC;
        state_next = ST_HIBER;
      end
      ST_ASSOC_REQ: begin
        send_now   = 1'b1;
        send_kind  = MSG_ASSOC_REQ;
        state_next = ST_ASSOC_WAIT;
      end
      ST_ASSOC_WAIT: begin
        if (rx_ok && (LINK_RX.kind == MSG_ACCEPT)) begin
          state_next = ST_ONLINE;
        end else if ((rx_ok && (LINK_RX.kind == MSG_REFUSE)) || wait_exp) begin
          state_next = assoc_reg ? ST_LOST : ST_RETRY; // RULE_09 RULE_10
        end
      end
      ST_RETRY, ST_LOST: begin
        if (wait_exp || manual_reg) begin
          state_next = ST_ASSOC_REQ;
        end
      end
      ST_ONLINE: begin
        if (pend_reg) begin
          if (!(rx_ok && (LINK_RX.kind == MSG_ACK)) && wait_exp) begin
            if (miss_reg == MISS_LIMIT) begin
              state_next = ST_LOST; // RULE_10
            end else begin
              send_now  = 1'b1;     // RULE_21
              send_kind = last_kind_reg;
              send_data = last_data_reg;
            end
          end
        end else if (temp_due) begin
          send_now  = 1'b1;
          send_kind = MSG_TEMP;
          send_data = temp_reg;
        end else if (setpt_due) begin
          send_now  = 1'b1;
          send_kind = MSG_SETPT;
          send_data = setpt_reg;
        end
      end
      default: state_next = ST_BOOT;
    endcase
    // Address 000 overrides every active state
    if (addr_zero && (state_reg != ST_BOOT) && (state_reg != ST_HIBER)
        && (state_reg != ST_DISASSOC)) begin
      state_next = ST_DISASSOC; // RULE_05
      send_now   = 1'b0;
    end
  end

  assign wait_clear = send_now || (state_next != state_reg);

  // ------------------------------
  // State register
  // ------------------------------
  // Boot waits two cycles so the synchronised switches are settled
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg     <= ST_BOOT;
      boot_wait_reg <= 1'b0;
      boot_done_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      boot_wait_reg <= 1'b1;
      boot_done_reg <= boot_wait_reg;
    end
  end

  // ------------------------------
  // Association memory and radio settings
  // ------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      assoc_reg     <= 1'b0;
      RADIO_POWER   <= 2'h0;
      RADIO_CHANNEL <= 4'h0;
    end else if (state_reg == ST_DISASSOC) begin
      assoc_reg     <= 1'b0; // RULE_05
      RADIO_POWER   <= 2'h0;
      RADIO_CHANNEL <= 4'h0;
    end else if ((state_reg == ST_ASSOC_WAIT) && (state_next == ST_ONLINE)) begin
      assoc_reg     <= 1'b1;
      RADIO_POWER   <= LINK_RX.power;   // RULE_16
      RADIO_CHANNEL <= LINK_RX.channel; // RULE_16
    end
  end

  // ------------------------------
  // Outstanding message bookkeeping
  // ------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_reg       <= 1'b0;
      miss_reg       <= 3'h0;
      force_temp_reg <= 1'b0;
      last_kind_reg  <= MSG_TEMP;
      last_data_reg  <= 16'h0000;
      last_temp_reg  <= 16'h0000;
      last_setpt_reg <= 16'h0000;
    end else if (state_next != ST_ONLINE) begin
      pend_reg       <= 1'b0;
      miss_reg       <= 3'h0;
      force_temp_reg <= 1'b1; // First report follows every (re)association
    end else if (send_now) begin
      pend_reg       <= 1'b1;
      miss_reg       <= pend_reg ? miss_reg + 3'h1 : 3'h0;
      force_temp_reg <= force_temp_reg && (send_kind != MSG_TEMP);
      last_kind_reg  <= send_kind;
      last_data_reg  <= send_data;
      if (send_kind == MSG_TEMP) begin
        last_temp_reg <= send_data;
      end
      if (send_kind == MSG_SETPT) begin
        last_setpt_reg <= send_data;
      end
    end else if (pend_reg && rx_ok && (LINK_RX.kind == MSG_ACK)) begin
      pend_reg <= 1'b0;
      miss_reg <= 3'h0;
    end
  end

  // ------------------------------
  // Modem transmit port
  // ------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK_TX   <= '0;
      HIBERNATE <= 1'b0;
    end else begin
      LINK_TX.valid <= send_now;
      LINK_TX.kind  <= send_kind;
      LINK_TX.addr  <= my_addr;
      LINK_TX.data  <= send_data;
      HIBERNATE     <= (state_next == ST_HIBER); // RULE_05
    end
  end

  // ------------------------------
  // Test lamps
  // ------------------------------
  // Lamps cost battery, so they go dark on their own after the window
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      test_prev_reg <= 1'b1;
      lamp_on_reg   <= 1'b0;
      STATUS_LAMP_A <= 1'b0;
      STATUS_LAMP_B <= 1'b0;
      STATUS_LAMP_C <= 1'b0;
      POWER_LAMP    <= 1'b0;
    end else begin
      test_prev_reg <= pin_sync_reg[1];
      if (test_prev_reg && !pin_sync_reg[1]) begin
        lamp_on_reg <= 1'b1;
      end else if (lamp_exp) begin
        lamp_on_reg <= 1'b0; // RULE_11
      end
      STATUS_LAMP_A <= lamp_on_reg && (LINK_RSSI >= 2'h1);
      STATUS_LAMP_B <= lamp_on_reg && (LINK_RSSI >= 2'h2);
      STATUS_LAMP_C <= lamp_on_reg && (LINK_RSSI == 2'h3);
      POWER_LAMP    <= lamp_on_reg && pin_sync_reg[0];
    end
  end

  // ------------------------------
  // APB slave: one wait-free access cycle
  // ------------------------------
  assign wr_en   = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_en   = PSEL && !PENABLE && !PWRITE;
  assign wdat_sp = (PWDATA[15:0] < SETPT_MIN) ? SETPT_MIN
                 : (PWDATA[15:0] > SETPT_MAX) ? SETPT_MAX : PWDATA[15:0]; // RULE_13

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && (PADDR != REG_CTRL) && (PADDR != REG_TEMP)
              && (PADDR != REG_SETPT) && (PADDR != REG_STATUS);
      if (rd_en) begin
        case (PADDR)
          REG_CTRL:   PRDATA <= {31'h0, manual_reg};
          REG_TEMP:   PRDATA <= {16'h0, temp_reg};
          REG_SETPT:  PRDATA <= {16'h0, setpt_reg};
          REG_STATUS: PRDATA <= {13'h0, miss_reg, RADIO_CHANNEL, 1'b0, RADIO_POWER,
                                 assoc_reg, state_reg};
          default:    PRDATA <= 32'h0;
        endcase
      end
    end
  end

  // Software-written measurements and the manual association request
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      temp_reg   <= TEMP_BAND_LO;
      setpt_reg  <= SETPT_MIN;
      manual_reg <= 1'b0;
    end else begin
      if (wr_en && (PADDR == REG_TEMP)) begin
        temp_reg <= PWDATA[15:0];
      end
      if (wr_en && (PADDR == REG_SETPT)) begin
        setpt_reg <= wdat_sp;
      end
      if (wr_en && (PADDR == REG_CTRL) && PWDATA[CTRL_ASSOC_BIT]) begin
        manual_reg <= 1'b1;
      end else if (state_reg == ST_ASSOC_REQ) begin
        manual_reg <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// >>> bench/wslc_sensor_ctrl_assertions.sv
// Port checker of the sensor link controller
`timescale 1ns/1ps
`default_nettype none
module wslc_sensor_ctrl_chk
  import wslc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = 20
) (
  // Clock, reset and switches
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic [3:0] ADDRESS_DIGIT_HUNDREDS,
  input wire logic [3:0] ADDRESS_DIGIT_TENS,
  input wire logic [3:0] ADDRESS_DIGIT_UNITS,
  // Link, radio and lamps
  input wire wslc_rx_t   LINK_RX,
  input wire wslc_tx_t   LINK_TX,
  input wire logic [1:0] RADIO_POWER,
  input wire logic [3:0] RADIO_CHANNEL,
  input wire logic       STATUS_LAMP_A,
  input wire logic       STATUS_LAMP_B,
  input wire logic       STATUS_LAMP_C,
  input wire logic       HIBERNATE
);
  logic [9:0]  sw;
  logic        tx_t, rx_a, seen_q;
  logic [3:0]  cyc_q;
  int unsigned gap_q, lit_q;
  // Decimal switch value and link events
  assign sw = 10'(ADDRESS_DIGIT_HUNDREDS) * 10'h064 + 10'(ADDRESS_DIGIT_TENS) * 10'h00A
    + 10'(ADDRESS_DIGIT_UNITS);
  assign tx_t = LINK_TX.valid && LINK_TX.kind == MSG_TEMP;
  assign rx_a = LINK_RX.valid && LINK_RX.kind == MSG_ACCEPT && LINK_RX.addr == sw;
  // Cycles since release and last report, and lamps lit
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cyc_q  <= 4'h0;
      gap_q  <= 0;
      lit_q  <= 0;
      seen_q <= 1'b0;
    end else begin
      cyc_q  <= (cyc_q == 4'hF) ? cyc_q : cyc_q + 4'h1;
      gap_q  <= tx_t ? 0 : gap_q + 1;
      lit_q  <= STATUS_LAMP_A ? lit_q + 1 : 0;
      seen_q <= tx_t | (seen_q & !rx_a); // Report after accept is free
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  a_tx_own_addr: assert property (LINK_TX.valid && LINK_TX.kind != MSG_DISASSOC |-> LINK_TX.addr == sw)
    else $error("bad address");
  a_boot_request: assert property (cyc_q == 4'h1 && sw != 10'h000 |-> ##[0:8] (LINK_TX.valid && LINK_TX.kind == MSG_ASSOC_REQ))
    else $error("no request");
  a_disassoc_hiber: assert property (LINK_TX.valid && LINK_TX.kind == MSG_DISASSOC |-> ##[1:8] HIBERNATE)
    else $error("no sleep");
  a_hiber_quiet: assert property (HIBERNATE && $past(HIBERNATE) |-> !LINK_TX.valid)
    else $error("send asleep");
  a_radio_accept: assert property (rx_a |=> RADIO_POWER == $past(LINK_RX.power) && RADIO_CHANNEL == $past(LINK_RX.channel))
    else $error("radio not set");
  a_temp_gap: assert property (tx_t && seen_q |-> gap_q >= 29 * TICK_CYCLES_P)
    else $error("report too soon");
  a_lamp_time: assert property (lit_q <= 6 * TICK_CYCLES_P + 8)
    else $error("lamps lit too long");
  a_lamp_scale: assert property (STATUS_LAMP_C |-> STATUS_LAMP_B && STATUS_LAMP_A)
    else $error("lamp order");
  c_accept: cover property (rx_a);
  c_temp: cover property (tx_t && seen_q);
  c_hiber: cover property ($rose(HIBERNATE));
endmodule
bind wslc_sensor_ctrl wslc_sensor_ctrl_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (.*);
`default_nettype wire

// >>> bench/wslc_rx_model.sv
// Behavioural receiver at the far side of the radio link
`timescale 1ns/1ps
`default_nettype none
module wslc_rx_model
  import wslc_pkg::*;
(
  // Clock, reset and behaviour: mode 0 silent, 1 accept and ack, 2 refuse and ack
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] my_addr,
  input  wire logic [1:0] mode,
  input  wire logic [3:0] lat,
  // Radio link and replicated temperature
  input  wire wslc_tx_t   tx,
  output wslc_rx_t        rx,
  output logic [15:0]     zone_out
);
  logic [2:0] kind_q;
  logic [3:0] wait_q;
  logic       assoc_q;
  // Answer lat+1 cycles after sampling a request; idle fields toggle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx       <= '0;
      wait_q   <= 4'h0;
      kind_q   <= 3'h0;
      assoc_q  <= 1'b0;
      zone_out <= 16'h02D5;
    end else begin
      rx     <= {1'b0, ~rx[18:0]};
      wait_q <= (wait_q != 4'h0) ? wait_q - 4'h1 : 4'h0;
      if (my_addr == 10'h000) begin
        assoc_q  <= 1'b0;
        zone_out <= 16'h02D5;
      end else if (tx.valid && (tx.addr == my_addr || tx.kind == MSG_DISASSOC)) begin
        kind_q <= tx.kind;
        wait_q <= lat + 4'h1;
        if (tx.kind == MSG_DISASSOC) assoc_q <= 1'b0;
        if (tx.kind == MSG_TEMP) zone_out <= (tx.data < 16'h0140) ? 16'h0140 :
          (tx.data > 16'h04C4) ? 16'h04C4 : tx.data;
      end else if (wait_q == 4'h1 && mode != 2'h0 && kind_q != MSG_DISASSOC) begin
        if (kind_q == MSG_ASSOC_REQ) begin
          rx      <= '{1'b1, (mode == 2'h1) ? MSG_ACCEPT : MSG_REFUSE, my_addr, 2'h2, 4'hA};
          assoc_q <= (mode == 2'h1);
        end else rx <= '{1'b1, MSG_ACK, my_addr, 2'h0, 4'h0};
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_wslc_sensor_ctrl.sv
// Self-checking bench of the sensor link controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_wslc_sensor_ctrl;
  import wslc_pkg::*;
  localparam int TK = 20;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, test_n = 1'b1;
  logic bat = 1'b1, pready, perr, la, lb, lc, lp, hib;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] dh = 4'h1, dt = 4'h2, du = 4'h3, rch;
  logic [1:0] rssi = 2'h3, mode = 2'h2, rpow;
  logic [15:0] zone;
  wslc_rx_t rx;
  wslc_tx_t tx;
  int bad_count = 0, n_checks = 0, c;
  wslc_sensor_ctrl #(.TICK_CYCLES_P(TK)) dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(perr), .ADDRESS_DIGIT_HUNDREDS(dh), .ADDRESS_DIGIT_TENS(dt),
    .ADDRESS_DIGIT_UNITS(du), .TEST_BUTTON_N(test_n), .BATTERY_OK(bat), .LINK_RSSI(rssi),
    .LINK_RX(rx), .LINK_TX(tx), .RADIO_POWER(rpow), .RADIO_CHANNEL(rch),
    .STATUS_LAMP_A(la), .STATUS_LAMP_B(lb), .STATUS_LAMP_C(lc), .POWER_LAMP(lp),
    .HIBERNATE(hib));
  wslc_rx_model u_rx (.clk(clk), .rst_n(rst_n), .my_addr(10'h07B), .mode(mode),
    .lat(4'h3), .tx(tx), .rx(rx), .zone_out(zone));
  always #2.5 clk = ~clk;
  // Closing report
  task automatic end_sim();
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer, entered after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    `CHK(perr, (a > REG_STATUS))
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Wait for a message kind, at most lim cycles
  task automatic wtx(input logic [2:0] k, input int lim);
    c = 0;
    do begin @(posedge clk); c++; end while (!(tx.valid === 1'b1 && tx.kind === k) && c < lim);
  endtask
  initial begin #400us; bad_count++; end_sim(); end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1, REG_SETPT, 32'h1F4); apb(0, REG_SETPT, 0); `CHK(rd, 32'h140)
    apb(1, REG_SETPT, 32'h010); apb(0, REG_SETPT, 0); `CHK(rd, 32'h064)
    apb(0, 8'h10, 0); `CHK(rd, 32'h0)
    apb(0, REG_STATUS, 0); `CHK(rd[7:0], 8'h20)
    mode <= 2'h1;
    wtx(MSG_ASSOC_REQ, 700 * TK); `CHK(c >= 598 * TK && c <= 600 * TK, 1'b1)
    wtx(MSG_TEMP, 10); `CHK(tx.data, 16'h0258)
    `CHK({rpow, rch}, 6'h2A)
    apb(1, REG_TEMP, 32'h25A); wtx(MSG_TEMP, 40 * TK); `CHK(tx.data, 16'h025A)
    apb(1, REG_SETPT, 32'h065); wtx(MSG_SETPT, 40 * TK); `CHK(tx.data, 16'h0065)
    // Lamp test at two strengths
    repeat (2) begin
      test_n <= 1'b0;
      repeat (4) @(posedge clk);
      test_n <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK({la, lb, lc, lp}, (rssi == 2'h3) ? 4'hF : 4'h8)
      repeat (7 * TK) @(posedge clk);
      `CHK({la, lb, lc, lp}, 4'h0)
      rssi <= 2'h1;
      bat <= 1'b0;
    end
    // Silent receiver: resend, lost, manual request
    mode <= 2'h0;
    apb(1, REG_TEMP, 32'h4B0); wtx(MSG_TEMP, 40 * TK);
    wtx(MSG_TEMP, 40 * TK); `CHK(c >= 29 * TK && c <= 31 * TK, 1'b1)
    `CHK(tx.data, 16'h04B0)
    repeat (95 * TK) @(posedge clk);
    apb(0, REG_STATUS, 0); `CHK(rd[7:0], 8'h80)
    mode <= 2'h1;
    apb(1, REG_CTRL, 32'h1); wtx(MSG_ASSOC_REQ, 10 * TK); `CHK(c < 10 * TK, 1'b1)
    // Address 000 leaves the link and sleeps
    {dh, dt, du} <= 12'h000;
    wtx(MSG_DISASSOC, 20 * TK); `CHK(c < 20 * TK, 1'b1)
    repeat (10) @(posedge clk);
    `CHK({hib, rpow}, 3'h4)
    end_sim();
  end
endmodule
`default_nettype wire
